// >>> lcdc_host.sv
// Purpose: host processor model on the 8-bit parallel port of the decoder
// Assumes: strobes spaced at least 8 clocks, data held 3 clocks around the strobe edge
// Notes: a released data line shows the inverse of the last byte, never a stale copy
`timescale 1ns/10ps
module lcdc_host (
    input  wire logic       clk_i,
    input  wire logic       busy_i,
    input  wire logic       oe_i,
    input  wire logic [7:0] rd_data_i,
    output logic            sel_o,
    output logic            wr_n_o,
    output logic            rd_n_o,
    output logic      [7:0] data_o
);
    initial begin
        sel_o  = 1'b0;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        data_o = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic write_byte(input logic sel, input logic [7:0] val);
        int guard;
        guard = 0;
        // writes taken while full are lost, so wait it out
        while (busy_i !== 1'b0 && guard < 100) begin
            tick(1);
            guard++;
        end
        sel_o  = sel;
        data_o = val;
        tick(4);
        wr_n_o = 1'b0;
        tick(4);
        wr_n_o = 1'b1;
        tick(3);
        data_o = ~val;
        tick(5);
    endtask
    task automatic read_byte(output logic [7:0] val, output logic oe);
        sel_o = 1'b1;
        tick(4);
        rd_n_o = 1'b0;
        tick(6);
        val = rd_data_i;
        oe  = oe_i;
        rd_n_o = 1'b1;
        tick(5);
    endtask
endmodule

// >>> lcdc_pkg.sv
// Purpose: types of the lcd driver command decoder
// Assumes: nothing beyond the constants header
// Notes: host bytes travel through the fifo as an lcdc_word_t
package lcdc_pkg;
    typedef struct packed {
        logic       data_sel;
        logic [7:0] value;
    } lcdc_word_t;
    typedef struct packed {
        logic       booster;
        logic       regulator;
        logic       follower;
    } lcdc_power_t;
    typedef enum logic [1:0] {
        LCDC_ST_IDLE  = 2'b00,
        LCDC_ST_WRITE = 2'b01,
        LCDC_ST_READ  = 2'b10
    } lcdc_state_t;
endpackage

// >>> lcdc_regs.svh
// Purpose: constants of the lcd driver command decoder
// Assumes: 8-bit host port, 5 pages of 80 columns of display memory
// Notes: command codes are matched with their option bits masked off
`ifndef LCDC_REGS_SVH
`define LCDC_REGS_SVH
`define LCDC_CMD_DISP     8'hAE
`define LCDC_CMD_ADC      8'hA0
`define LCDC_CMD_STATIC   8'hA4
`define LCDC_CMD_DUTY     8'hA8
`define LCDC_CMD_DUTY1    8'hAA
`define LCDC_CMD_CLKSTOP  8'hE6
`define LCDC_MASK_BIT     8'hFE
`define LCDC_CMD_RMW      8'hE0
`define LCDC_CMD_END      8'hEE
`define LCDC_CMD_RESET    8'hE2
`define LCDC_CMD_POWER    8'hB0
`define LCDC_MASK_POWER   8'hF8
`define LCDC_CMD_CONTRAST 8'h80
`define LCDC_MASK_CONTR   8'hE0
`define LCDC_CMD_LINE     8'hC0
`define LCDC_CMD_PAGE     8'hB8
`define LCDC_CMD_COLUMN   8'h00
`define LCDC_MASK_COLUMN  8'h80
`define LCDC_COL_LAST     7'h4F
`define LCDC_PAGE_IND     3'h4
`define LCDC_RST_POWER    3'h0
`define LCDC_RST_CONTRAST 5'h00
`define LCDC_RST_DUTY     1'b1
`endif

// >>> lcdc_top.sv
// Purpose: command decoder, display memory and a 32-word write fifo
// Assumes: host strobes arrive asynchronous and are synchronised here
// Notes: writes queue in the fifo; a read waits until the fifo is drained
`timescale 1ns/10ps
`include "lcdc_regs.svh"
module lcdc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      wr_next;
    logic [AW:0]      rd_reg;
    logic [AW:0]      rd_next;
    logic             push;
    logic             pop;
    always_comb begin
        in_ready_o  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
        out_valid_o = wr_reg != rd_reg;
        out_data_o  = mem[rd_reg[AW-1:0]];
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wr_next     = push ? wr_reg + 1'b1 : wr_reg;
        rd_next     = pop ? rd_reg + 1'b1 : rd_reg;
    end
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end
endmodule

module lcdc_top #(
    parameter int COLUMNS = 80,
    parameter int DEPTH   = 32
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       command_data_select_i,
    input  wire logic       wr_n_i,
    input  wire logic       rd_n_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    output logic            busy_o,
    output logic            display_on_o,
    output logic            seg_reverse_o,
    output logic            all_lit_o,
    output logic            duty_sixteen_o,
    output logic            duty_plus_one_o,
    output logic            indicator_common_pin_o,
    output logic            power_save_o,
    output logic      [2:0] power_circuit_enables_o,
    output logic      [4:0] contrast_level_o,
    output logic      [4:0] start_line_o,
    output logic            display_clock_out_o,
    output logic            outputs_at_supply_o
);
    logic [2:0] wr_sync_reg;
    logic [2:0] rd_sync_reg;
    logic       sel_s1_reg;
    logic       sel_s2_reg;
    logic [7:0] d_s1_reg;
    logic [7:0] d_s2_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_sync_reg <= 3'h7;
            rd_sync_reg <= 3'h7;
            sel_s1_reg  <= 1'b0;
            sel_s2_reg  <= 1'b0;
            d_s1_reg    <= 8'h00;
            d_s2_reg    <= 8'h00;
        end else begin
            wr_sync_reg <= {wr_sync_reg[1:0], wr_n_i};
            rd_sync_reg <= {rd_sync_reg[1:0], rd_n_i};
            sel_s1_reg  <= command_data_select_i;
            sel_s2_reg  <= sel_s1_reg;
            d_s1_reg    <= data_i;
            d_s2_reg    <= d_s1_reg;
        end
    end
    // write strobe taken at its rising (release) edge, data settled by then; read strobe taken at its falling edge
    logic wr_ev;
    logic rd_ev;
    assign wr_ev = wr_sync_reg[2:1] == 2'b01;
    assign rd_ev = rd_sync_reg[2:1] == 2'b10;

    lcdc_pkg::lcdc_word_t in_word;
    lcdc_pkg::lcdc_word_t q_word;
    logic                 q_valid;
    logic                 q_ready;
    logic                 in_ready;
    assign in_word.data_sel = sel_s2_reg;
    assign in_word.value    = d_s2_reg;
    lcdc_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (in_word),
        .in_valid_i  (wr_ev),
        .in_ready_o  (in_ready),
        .out_data_o  (q_word),
        .out_valid_o (q_valid),
        .out_ready_i (q_ready)
    );

    function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] code,
                                    input logic [7:0] mask);
        return (b & mask) == code;
    endfunction

    logic [7:0] ram [5*COLUMNS];
    logic [6:0] col_reg,   col_next;
    logic [6:0] saved_reg, saved_next;
    logic [2:0] page_reg,  page_next;
    logic [4:0] line_reg,  line_next;
    logic [4:0] contr_reg, contr_next;
    logic [2:0] pwr_reg,   pwr_next;
    logic       on_reg, on_next, adc_reg, adc_next, stat_reg, stat_next;
    logic       duty_reg, duty_next, dp1_reg, dp1_next, rmw_reg, rmw_next;
    logic       cstop_reg, cstop_next, ps_reg, ps_next;
    logic [7:0] latch_reg, latch_next;
    logic       ram_we;
    logic [7:0] ram_wdata;
    logic [8:0] addr;
    logic [7:0] cmd;
    logic       pend_rd_reg, pend_rd_next;
    logic [3:0] clkdiv_reg, clkdiv_next;

    assign addr = 9'(page_reg) * 9'(COLUMNS) + 9'(col_reg);
    assign cmd  = q_word.value;
    // reads wait for queued writes so they see fresh memory
    assign q_ready = 1'b1;

    function automatic logic [6:0] col_inc(input logic [6:0] c);
        return (c == `LCDC_COL_LAST) ? c : c + 7'h01;
    endfunction

    always_comb begin
        col_next = col_reg; saved_next = saved_reg; page_next = page_reg;
        line_next = line_reg; contr_next = contr_reg; pwr_next = pwr_reg;
        on_next = on_reg; adc_next = adc_reg; stat_next = stat_reg;
        duty_next = duty_reg; dp1_next = dp1_reg; rmw_next = rmw_reg;
        cstop_next = cstop_reg; ps_next = ps_reg; latch_next = latch_reg;
        ram_we = 1'b0; ram_wdata = cmd;
        pend_rd_next = pend_rd_reg || rd_ev;
        if (q_valid && q_word.data_sel) begin
            ram_we   = 1'b1;
            // indicator page keeps only bit 0
            if (page_reg == `LCDC_PAGE_IND) ram_wdata = {7'h00, cmd[0]};
            col_next = col_inc(col_reg);
        end else if (q_valid) begin
            if (cmd_is(cmd, `LCDC_CMD_DISP, `LCDC_MASK_BIT)) begin
                on_next = cmd[0];
                if (cmd[0]) ps_next = 1'b0;
            end else if (cmd_is(cmd, `LCDC_CMD_ADC, `LCDC_MASK_BIT)) begin
                adc_next = cmd[0];
            end else if (cmd_is(cmd, `LCDC_CMD_STATIC, `LCDC_MASK_BIT)) begin
                stat_next = cmd[0];
                if (cmd[0] && !on_reg) begin
                    ps_next  = 1'b1;
                    pwr_next = `LCDC_RST_POWER;
                end
                if (!cmd[0]) ps_next = 1'b0;
            end else if (cmd_is(cmd, `LCDC_CMD_DUTY, `LCDC_MASK_BIT)) begin
                duty_next = cmd[0];
            end else if (cmd_is(cmd, `LCDC_CMD_DUTY1, `LCDC_MASK_BIT)) begin
                dp1_next = cmd[0];
            end else if (cmd_is(cmd, `LCDC_CMD_CLKSTOP, `LCDC_MASK_BIT)) begin
                cstop_next = cmd[0];
            end else if (cmd == `LCDC_CMD_RMW) begin
                rmw_next   = 1'b1;
                saved_next = col_reg;
            end else if (cmd == `LCDC_CMD_END) begin
                if (rmw_reg) col_next = saved_reg;
                rmw_next = 1'b0;
            end else if (cmd == `LCDC_CMD_RESET) begin
                line_next  = 5'h00;
                col_next   = 7'h00;
                page_next  = 3'h0;
                contr_next = `LCDC_RST_CONTRAST;
            end else if (cmd_is(cmd, `LCDC_CMD_POWER, `LCDC_MASK_POWER)) begin
                pwr_next = cmd[2:0];
            end else if (cmd_is(cmd, `LCDC_CMD_CONTRAST, `LCDC_MASK_CONTR)) begin
                contr_next = cmd[4:0];
            end else if (cmd_is(cmd, `LCDC_CMD_LINE, `LCDC_MASK_CONTR)) begin
                line_next = cmd[4:0];
            end else if (cmd_is(cmd, `LCDC_CMD_PAGE, `LCDC_MASK_POWER)) begin
                if (cmd[2:0] <= `LCDC_PAGE_IND) page_next = cmd[2:0];
            end else if (cmd_is(cmd, `LCDC_CMD_COLUMN, `LCDC_MASK_COLUMN)) begin
                if (cmd[6:0] <= `LCDC_COL_LAST) col_next = cmd[6:0];
            end
        end else if (pend_rd_reg) begin
            // fifo empty here, so memory holds all earlier writes
            pend_rd_next = rd_ev;
            if (sel_s2_reg) begin
                latch_next = ram[addr];
                if (!rmw_reg) col_next = col_inc(col_reg);
            end
        end
        clkdiv_next = clkdiv_reg + 4'h1;
    end

    always_ff @(posedge clk_i) begin
        if (ram_we) begin
            ram[addr] <= ram_wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            col_reg <= 7'h00; saved_reg <= 7'h00; page_reg <= 3'h0;
            line_reg <= 5'h00; contr_reg <= `LCDC_RST_CONTRAST;
            pwr_reg <= `LCDC_RST_POWER;
            on_reg <= 1'b0; adc_reg <= 1'b1; stat_reg <= 1'b0;
            duty_reg <= `LCDC_RST_DUTY; dp1_reg <= 1'b0; rmw_reg <= 1'b0;
            cstop_reg <= 1'b0; ps_reg <= 1'b0; latch_reg <= 8'h00;
            pend_rd_reg <= 1'b0; clkdiv_reg <= 4'h0;
        end else begin
            col_reg <= col_next; saved_reg <= saved_next; page_reg <= page_next;
            line_reg <= line_next; contr_reg <= contr_next; pwr_reg <= pwr_next;
            on_reg <= on_next; adc_reg <= adc_next; stat_reg <= stat_next;
            duty_reg <= duty_next; dp1_reg <= dp1_next; rmw_reg <= rmw_next;
            cstop_reg <= cstop_next; ps_reg <= ps_next; latch_reg <= latch_next;
            pend_rd_reg <= pend_rd_next; clkdiv_reg <= clkdiv_next;
        end
    end

    // output stage, every output registered
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o <= 8'h00; data_oe_o <= 1'b0; busy_o <= 1'b0;
            display_on_o <= 1'b0; seg_reverse_o <= 1'b0; all_lit_o <= 1'b0;
            duty_sixteen_o <= 1'b1; duty_plus_one_o <= 1'b0;
            indicator_common_pin_o <= 1'b0; power_save_o <= 1'b0;
            power_circuit_enables_o <= 3'h0; contrast_level_o <= 5'h00;
            start_line_o <= 5'h00; display_clock_out_o <= 1'b0;
            outputs_at_supply_o <= 1'b0;
        end else begin
            // bus shows the previously latched byte while the read strobe is low
            // taken at the read event, before this read's prefetch reloads the latch
            if (rd_ev && sel_s2_reg) data_o <= latch_reg;
            data_oe_o <= !rd_sync_reg[1] && sel_s2_reg;
            busy_o <= !in_ready;
            display_on_o <= on_reg && !ps_reg;
            seg_reverse_o <= adc_reg;
            all_lit_o <= stat_reg && !ps_reg;
            duty_sixteen_o <= duty_reg;
            duty_plus_one_o <= dp1_reg;
            indicator_common_pin_o <= dp1_reg && ram[9'(`LCDC_PAGE_IND) * 9'(COLUMNS)][0];
            power_save_o <= ps_reg;
            power_circuit_enables_o <= ps_reg ? 3'h0 : pwr_reg;
            contrast_level_o <= pwr_reg[1] ? contr_reg : 5'h00;
            start_line_o <= line_reg;
            display_clock_out_o <= !cstop_reg && !ps_reg && clkdiv_reg[3];
            outputs_at_supply_o <= ps_reg;
        end
    end

    property p_ps_entry;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q_valid && !q_word.data_sel && cmd == 8'hA5 && !on_reg) |=> ps_reg && pwr_reg == 3'h0;
    endproperty
    a_ps_entry: assert property (p_ps_entry) else $error("power save not entered");
    property p_ps_clk;
        @(posedge clk_i) disable iff (!rst_n_i) ps_reg |=> !display_clock_out_o;
    endproperty
    a_ps_clk: assert property (p_ps_clk) else $error("clock runs in power save");
    property p_end;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q_valid && !q_word.data_sel && cmd == 8'hEE && rmw_reg) |=> col_reg == $past(saved_reg);
    endproperty
    a_end: assert property (p_end) else $error("column not restored");
    property p_wr_inc;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q_valid && q_word.data_sel && col_reg < 7'h4F) |=> col_reg == $past(col_reg) + 7'h01;
    endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("write did not advance");
    property p_contr;
        @(posedge clk_i) disable iff (!rst_n_i) !pwr_reg[1] |=> contrast_level_o == 5'h00;
    endproperty
    a_contr: assert property (p_contr) else $error("contrast without regulator");
    property p_rst_keep;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q_valid && !q_word.data_sel && cmd == 8'hE2) |=> pwr_reg == $past(pwr_reg) && col_reg == 7'h00;
    endproperty
    a_rst_keep: assert property (p_rst_keep) else $error("soft reset wrong");
    property p_rmw_rd;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rmw_reg && !q_valid && pend_rd_reg) |=> col_reg == $past(col_reg);
    endproperty
    a_rmw_rd: assert property (p_rmw_rd) else $error("read moved column in rmw");
    property p_exit;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q_valid && !q_word.data_sel && cmd == 8'hAF) |=> !ps_reg ##1 !power_save_o;
    endproperty
    a_exit: assert property (p_exit) else $error("power save not left");
    property p_rd_prev;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_ev && sel_s2_reg) |=> data_o == $past(latch_reg);
    endproperty
    a_rd_prev: assert property (p_rd_prev) else $error("read not from old latch");
    property p_seg;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q_valid && !q_word.data_sel && (cmd & 8'hFE) == 8'hA0) |=> adc_reg == $past(cmd[0]);
    endproperty
    a_seg: assert property (p_seg) else $error("segment direction not taken");
    property p_soft_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q_valid && !q_word.data_sel && cmd == 8'hE2) |=> line_reg == 5'h00 && page_reg == 3'h0;
    endproperty
    a_soft_clr: assert property (p_soft_clr) else $error("soft reset left state");
    property p_cstop;
        @(posedge clk_i) disable iff (!rst_n_i) cstop_reg |=> !display_clock_out_o;
    endproperty
    a_cstop: assert property (p_cstop) else $error("clock output not stopped");
    property p_lit;
        @(posedge clk_i) disable iff (!rst_n_i) (stat_reg && !ps_reg) |=> all_lit_o;
    endproperty
    a_lit: assert property (p_lit) else $error("static drive not lit");
    c_ps:   cover property (@(posedge clk_i) ps_reg ##1 !ps_reg);
    c_rd:   cover property (@(posedge clk_i) rd_ev && rmw_reg);
    c_ind:  cover property (@(posedge clk_i) indicator_common_pin_o);
    c_rmw:  cover property (@(posedge clk_i) rmw_reg ##1 !rmw_reg);
    c_full: cover property (@(posedge clk_i) !in_ready);
endmodule

// >>> lcdc_top_tb_top.sv
// Purpose: self-checking bench of the lcd command decoder
// Assumes: host model drives the port, one byte per strobe
// Notes: first read after a column set returns the previous latch and is discarded
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module lcdc_top_tb_top;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       sel, wr_n, rd_n, oe, busy, disp_on, seg_rev, all_lit, duty16, duty1;
    logic       ind, psave, clk_out, at_supply;
    logic [7:0] din, dout;
    logic [2:0] power;
    logic [4:0] contrast, line;
    int         n_mismatch = 0;
    int         checked = 0;
    always #50 clk_i = ~clk_i;
    lcdc_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .command_data_select_i(sel),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .data_i(din), .data_o(dout), .data_oe_o(oe),
        .busy_o(busy), .display_on_o(disp_on), .seg_reverse_o(seg_rev), .all_lit_o(all_lit),
        .duty_sixteen_o(duty16), .duty_plus_one_o(duty1), .indicator_common_pin_o(ind),
        .power_save_o(psave), .power_circuit_enables_o(power), .contrast_level_o(contrast),
        .start_line_o(line), .display_clock_out_o(clk_out), .outputs_at_supply_o(at_supply));
    lcdc_host host (.clk_i(clk_i), .busy_i(busy), .oe_i(oe), .rd_data_i(dout), .sel_o(sel),
        .wr_n_o(wr_n), .rd_n_o(rd_n), .data_o(din));
    task automatic cmd(input logic [7:0] v);
        host.write_byte(1'b0, v);
    endtask
    task automatic dat(input logic [7:0] v);
        host.write_byte(1'b1, v);
    endtask
    task automatic rd_chk(input logic [7:0] exp);
        logic [7:0] v;
        logic       o;
        host.read_byte(v, o);
        `CHK(v, exp)
        `CHK(o, 1'b1)
    endtask
    task automatic dummy_read();
        logic [7:0] v;
        logic       o;
        host.read_byte(v, o);
    endtask
    task automatic count_toggles(output logic any);
        logic last;
        any  = 1'b0;
        last = clk_out;
        repeat (64) begin
            host.tick(1);
            if (clk_out !== last) any = 1'b1;
            last = clk_out;
        end
    endtask
    task automatic t_config();
        logic b;
        for (int i = 0; i < 2; i++) begin
            b = i[0];
            cmd(8'hA0 | 8'(i));
            `CHK(seg_rev, b)
            cmd(8'hA8 | 8'(i));
            `CHK(duty16, b)
            cmd(8'hAA | 8'(i));
            `CHK(duty1, b)
            cmd(8'hAE | 8'(i));
            `CHK(disp_on, b)
        end
        cmd(8'hBC);
        cmd(8'h00);
        dat(8'hFF);
        `CHK(ind, 1'b1)
        $display("test config done");
    endtask
    task automatic t_data();
        cmd(8'hB8);
        cmd(8'h05);
        dat(8'hAA);
        dat(8'h55);
        dat(8'hC3);
        cmd(8'h05);
        dummy_read();
        rd_chk(8'hAA);
        rd_chk(8'h55);
        rd_chk(8'hC3);
        $display("test data done");
    endtask
    task automatic t_rmw();
        cmd(8'h0A);
        dat(8'h11);
        dat(8'h22);
        cmd(8'h0A);
        cmd(8'hE0);
        dummy_read();
        rd_chk(8'h11);
        rd_chk(8'h11);
        cmd(8'hA1);
        dat(8'h99);
        dat(8'h98);
        cmd(8'hEE);
        dummy_read();
        rd_chk(8'h99);
        rd_chk(8'h98);
        $display("test rmw done");
    endtask
    task automatic t_power();
        cmd(8'hB7);
        `CHK(power, 3'h7)
        cmd(8'h9F);
        `CHK(contrast, 5'h1F)
        cmd(8'hB5);
        `CHK(contrast, 5'h00)
        cmd(8'hB7);
        `CHK(contrast, 5'h1F)
        cmd(8'hB9);
        cmd(8'h20);
        cmd(8'hC7);
        `CHK(line, 5'h07)
        cmd(8'hE2);
        `CHK(contrast, 5'h00)
        `CHK(line, 5'h00)
        `CHK(power, 3'h7)
        dat(8'h5A);
        cmd(8'hB8);
        cmd(8'h00);
        dummy_read();
        rd_chk(8'h5A);
        $display("test power done");
    endtask
    task automatic t_save();
        logic any;
        cmd(8'hAF);
        cmd(8'hA5);
        `CHK(all_lit, 1'b1)
        `CHK(psave, 1'b0)
        cmd(8'hA4);
        `CHK(all_lit, 1'b0)
        cmd(8'hAE);
        cmd(8'hA5);
        `CHK(psave, 1'b1)
        `CHK(power, 3'h0)
        `CHK(at_supply, 1'b1)
        count_toggles(any);
        `CHK(any, 1'b0)
        cmd(8'hA4);
        `CHK(psave, 1'b0)
        cmd(8'hA5);
        cmd(8'hAF);
        `CHK(psave, 1'b0)
        cmd(8'hB7);
        `CHK(power, 3'h7)
        cmd(8'hE6);
        count_toggles(any);
        `CHK(any, 1'b1)
        cmd(8'hE7);
        count_toggles(any);
        `CHK(any, 1'b0)
        cmd(8'hA1);
        cmd(8'hA9);
        `CHK(seg_rev, 1'b1)
        `CHK(duty16, 1'b1)
        $display("test save done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        host.tick(20);
        rst_n_i = 1'b1;
        host.tick(2);
        `CHK(disp_on, 1'b0)
        `CHK(duty16, 1'b1)
        `CHK(power, 3'h0)
        `CHK(contrast, 5'h00)
        `CHK(busy, 1'b0)
        t_config();
        t_data();
        t_rmw();
        t_power();
        t_save();
        finish_test();
    end
endmodule
